// File: design/pcrc_pkg.sv
// Purpose: shared constants and carrier types for the programmable crc engine
// Assumes: one clock, no software bus; configuration arrives on plain ports
// Notes: widths and reset values live here only
package pcrc_pkg;
  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int unsigned MAX_ORDER = 32;
  localparam int unsigned LEN_W = 5;
  localparam int unsigned LEN_LSB = 0;
  localparam int unsigned HALF_W = 16;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] STATE_RST = 32'h0000_0000;
  localparam logic [4:0] LEN_RST = 5'h00;

  // configuration carrier: control word two plus both mask halves
  typedef struct packed {
    logic [15:0] crc_control_two;
    logic [15:0] xor_mask_high;
    logic [15:0] xor_mask_low;
  } pcrc_cfg_s;

  // engine state machine
  typedef enum logic [0:0] {
    PCRC_IDLE = 1'b0,
    PCRC_RUN = 1'b1
  } pcrc_state_e;
endpackage

// File: design/pcrc_taps.sv
// Purpose: builds the feedback tap vector from mask and the top-term one-hot from length
// Assumes: length field holds order minus one
// Notes: purely combinational
`timescale 1ns/1ns
module pcrc_taps #(
  parameter int unsigned W = 32
) (
  input wire logic [W-1:0] mask,
  input wire logic [4:0] len_m1,
  output logic [W-1:0] taps,
  output logic [W-1:0] top_sel
);
  // ------------------------------------------------------------
  // tap decode
  // ------------------------------------------------------------
  // bit 0 is forced: the x^0 term always feeds back, mask bit 0 ignored
  assign taps = {mask[W-1:1], 1'b1}; // [RULE_05] [RULE_03] [RULE_04]
  // one-hot of the state bit that holds the top term; x^N needs no mask bit
  assign top_sel = W'(1) << len_m1; // [RULE_06] [RULE_07]
endmodule

// File: design/pcrc_engine.sv
// Purpose: programmable crc engine, one data bit per clock
// Assumes: configuration ports are static or on CLK; DATA_BIT is on CLK
// Notes: result is the low N bits of RESULT, upper bits zeroed on each step or clear; a held state is not re-trimmed
//
// Overview of operation
// [RULE_01] polynomials of any order up to 32, state and mask at most 32 bits
// [RULE_02] five bit length field in control word two bits 4:0 selects order
// [RULE_03] a set mask bit puts an xor at that state position
// [RULE_04] a clear mask bit applies no xor at that position
// [RULE_05] the x^0 term always feeds back; mask bit 0 is ignored
// [RULE_06] the top term of length N is always present regardless of mask
// [RULE_07] order 32 top term needs no mask storage bit
// [RULE_08] software writes order minus one: 01111 is 16, 11111 is 32
// [RULE_09] one data bit per clock shifts in; state clears on reset
`timescale 1ns/1ns
module pcrc_engine #(
  parameter int unsigned W = pcrc_pkg::MAX_ORDER
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire pcrc_pkg::pcrc_cfg_s CFG,
  input wire logic CLEAR,
  input wire logic DATA_VALID,
  input wire logic DATA_BIT,
  output logic [W-1:0] RESULT,
  output logic BUSY
);
  // ------------------------------------------------------------
  // configuration decode
  // ------------------------------------------------------------
  logic [4:0] len_m1;
  logic [W-1:0] mask;
  logic [W-1:0] taps;
  logic [W-1:0] top_sel;
  logic [W-1:0] len_mask;
  // order minus one, as software programs it
  assign len_m1 = CFG.crc_control_two[pcrc_pkg::LEN_LSB +: pcrc_pkg::LEN_W]; // [RULE_02] [RULE_08]
  assign mask = W'({CFG.xor_mask_high, CFG.xor_mask_low}); // [RULE_01]

  pcrc_taps #(
    .W(W)
  ) u_taps (
    .mask(mask),
    .len_m1(len_m1),
    .taps(taps),
    .top_sel(top_sel)
  );

  // ones over the low N bits; (top_sel<<1)-1 wraps cleanly at N=32
  assign len_mask = W'((top_sel << 1) - W'(1));

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  pcrc_pkg::pcrc_state_e state_q, state_d;
  logic [W-1:0] crc_q, crc_d;
  logic fb;
  logic [W-1:0] shifted;
  // feedback comes from the top term position, so x^N is always used
  assign fb = |(crc_q & top_sel) ^ DATA_BIT; // [RULE_06]
  // shifting within N bits; taps outside the length are masked off
  assign shifted = W'(crc_q << 1) & len_mask;
  assign crc_d = CLEAR ? W'(pcrc_pkg::STATE_RST) :
                 DATA_VALID ? (shifted ^ ({W{fb}} & taps & len_mask)) : crc_q; // [RULE_09] [RULE_03] [RULE_04]

  // state machine only reports activity; a gap of valid returns to idle
  always_comb begin
    case (state_q)
      pcrc_pkg::PCRC_IDLE: state_d = DATA_VALID ? pcrc_pkg::PCRC_RUN : pcrc_pkg::PCRC_IDLE;
      pcrc_pkg::PCRC_RUN: state_d = DATA_VALID ? pcrc_pkg::PCRC_RUN : pcrc_pkg::PCRC_IDLE;
      default: state_d = pcrc_pkg::PCRC_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // state clears on reset so every checksum starts from a known seed
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      crc_q <= W'(pcrc_pkg::STATE_RST); // [RULE_09]
      state_q <= pcrc_pkg::PCRC_IDLE;
    end else begin
      crc_q <= crc_d;
      state_q <= state_d;
    end
  end

  assign RESULT = crc_q;
  assign BUSY = (state_q == pcrc_pkg::PCRC_RUN);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // reference step built term by term from mask and length, so the shift
  // check does not lean on the tap and length-mask wires that it guards
  function automatic logic [W-1:0] ref_step(
    input logic [W-1:0] cur,
    input logic [W-1:0] msk,
    input logic [4:0] lm1,
    input logic din
  );
    logic [W-1:0] nxt;
    logic fb_bit;
    nxt = '0;
    fb_bit = cur[lm1] ^ din;
    for (int k = 0; k < W; k++) begin
      if (k == 0) begin
        nxt[k] = fb_bit;
      end else if (k <= int'(lm1)) begin
        nxt[k] = cur[k-1] ^ (fb_bit & msk[k]);
      end
    end
    return nxt;
  endfunction

  property p_shift_taps;
    @(posedge CLK) disable iff (!RSTN)
    (DATA_VALID && !CLEAR) |=> RESULT == ref_step($past(RESULT), $past(mask),
      $past(len_m1), $past(DATA_BIT));
  endproperty
  a_shift_taps: assert property (p_shift_taps) else $error("crc step wrong"); // [RULE_03]

  property p_clear_tap;
    @(posedge CLK) disable iff (!RSTN)
    (DATA_VALID && !CLEAR && !fb) |=> ((RESULT ^ W'($past(crc_q) << 1)) & $past(len_mask)) == '0;
  endproperty
  a_clear_tap: assert property (p_clear_tap) else $error("xor without feedback"); // [RULE_04]

  property p_bit0;
    @(posedge CLK) disable iff (!RSTN)
    (DATA_VALID && !CLEAR) |=> RESULT[0] == $past(fb);
  endproperty
  a_bit0: assert property (p_bit0) else $error("x0 term missing"); // [RULE_05]

  // only a loaded state is trimmed; a held state keeps the length it was built with
  property p_width;
    @(posedge CLK) disable iff (!RSTN)
    (DATA_VALID || CLEAR) |=> (RESULT & ~$past(len_mask)) == '0;
  endproperty
  a_width: assert property (p_width) else $error("bits above length set"); // [RULE_02]

  property p_top;
    @(posedge CLK) disable iff (!RSTN)
    (DATA_VALID && !CLEAR && !DATA_BIT && (crc_q & top_sel) != '0) |=> RESULT[0];
  endproperty
  a_top: assert property (p_top) else $error("top term ignored"); // [RULE_06]

  property p_len32;
    @(posedge CLK) disable iff (!RSTN)
    (len_m1 == 5'h1f) |-> len_mask == {W{1'b1}};
  endproperty
  a_len32: assert property (p_len32) else $error("order 32 mask wrong"); // [RULE_07]

  property p_clear;
    @(posedge CLK) disable iff (!RSTN)
    CLEAR |=> RESULT == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed"); // [RULE_09]

  property p_hold;
    @(posedge CLK) disable iff (!RSTN)
    (!DATA_VALID && !CLEAR) |=> $stable(RESULT);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while idle"); // [RULE_01]

  // ------------------------------------------------------------
  // activity, reset and decode checks
  // ------------------------------------------------------------
  // activity flag follows the strobe by one cycle; the release edge is skipped
  // because the state register is still held in reset there
  property p_busy;
    @(posedge CLK) disable iff (!RSTN)
    RSTN |=> BUSY == $past(DATA_VALID);
  endproperty
  a_busy: assert property (p_busy) else $error("busy does not follow valid"); // [RULE_09]

  property p_reset_idle;
    @(posedge CLK) disable iff (!RSTN)
    $rose(RSTN) |-> RESULT == '0 && !BUSY;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset left state"); // [RULE_09]

  // clear beats a data bit offered in the same cycle
  property p_clear_wins;
    @(posedge CLK) disable iff (!RSTN)
    (CLEAR && DATA_VALID) |=> RESULT == '0;
  endproperty
  a_clear_wins: assert property (p_clear_wins) else $error("data beat clear"); // [RULE_09]

  // order 16 programmed as 01111: low 16 bits live, top term in bit 15
  property p_len16;
    @(posedge CLK) disable iff (!RSTN)
    (len_m1 == 5'h0F) |-> len_mask == W'(32'h0000_FFFF) && top_sel[15];
  endproperty
  a_len16: assert property (p_len16) else $error("order 16 decode wrong"); // [RULE_02]

  // order 32 keeps its top term in the last state bit, no mask bit for it
  property p_top32;
    @(posedge CLK) disable iff (!RSTN)
    (len_m1 == 5'h1F) |-> top_sel[W-1];
  endproperty
  a_top32: assert property (p_top32) else $error("order 32 top term missing"); // [RULE_06]

  // mask bits 1 and up pass straight through; bit 0 always feeds back
  property p_taps_map;
    @(posedge CLK) disable iff (!RSTN)
    1'b1 |-> taps[0] && taps[W-1:1] == mask[W-1:1];
  endproperty
  a_taps_map: assert property (p_taps_map) else $error("tap map wrong"); // [RULE_03]

  property p_fb_zero;
    @(posedge CLK) disable iff (!RSTN)
    (DATA_VALID && !CLEAR && !fb) |=> !RESULT[0];
  endproperty
  a_fb_zero: assert property (p_fb_zero) else $error("x0 term without feedback"); // [RULE_05]

  // at order 32 the last state bit takes its neighbour plus its own tap
  property p_crc32;
    @(posedge CLK) disable iff (!RSTN)
    (len_m1 == 5'h1F && DATA_VALID && !CLEAR) |=> RESULT[W-1] ==
      ($past(RESULT[W-2]) ^ ($past(fb) & $past(mask[W-1])));
  endproperty
  a_crc32: assert property (p_crc32) else $error("order 32 top bit wrong"); // [RULE_07]
endmodule

// File: testbench/pcrc_engine_tb_top.sv
// Purpose: self-checking bench for the programmable crc engine
// Assumes: reference steps are worked out here from the shift rules
// Notes: bits go in msb first, one per clock
`timescale 1ns/1ns
module pcrc_engine_tb_top;
  logic CLK = 0, RSTN = 0, CLEAR = 0, DATA_VALID = 0, DATA_BIT = 0;
  pcrc_pkg::pcrc_cfg_s CFG = '0;
  logic [31:0] RESULT;
  logic BUSY;
  logic [31:0] e_q = '0;
  int n_fail = 0, check_count = 0;
  pcrc_engine uut (.CLK(CLK), .RSTN(RSTN), .CFG(CFG), .CLEAR(CLEAR),
    .DATA_VALID(DATA_VALID), .DATA_BIT(DATA_BIT), .RESULT(RESULT), .BUSY(BUSY));
  // ------------------------------------------------------------
  // clock, compare and reference step
  // ------------------------------------------------------------
  initial forever #5 CLK = ~CLK;
  task chk(string nm, logic [31:0] ex, logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // bit zero is forced in and taps above the order fall away under the low mask
  function logic [31:0] stp(logic [31:0] r, logic b);
    logic [31:0] lo;
    lo = 32'((64'h1 << (CFG.crc_control_two[4:0] + 1)) - 1);
    stp = ((r << 1) & lo) ^ ((r[CFG.crc_control_two[4:0]] ^ b) ?
      ({CFG.xor_mask_high, CFG.xor_mask_low} | 1) & lo : 32'h0000_0000);
  endfunction
  task setup(logic [4:0] len, logic [31:0] m);
    @(posedge CLK);
    CFG <= {11'h000, len, m};
    CLEAR <= 1;
    @(posedge CLK);
    CLEAR <= 0;
    e_q = '0;
    @(negedge CLK);
    chk("cleared", 32'h0000_0000, RESULT);
  endtask
  task shift(logic [31:0] d, int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge CLK);
      DATA_VALID <= 1;
      DATA_BIT <= d[i];
      e_q = stp(e_q, d[i]);
    end
    @(posedge CLK);
    DATA_VALID <= 0;
    @(negedge CLK);
    chk("result", e_q, RESULT);
    chk("busy", 32'h1, {31'h0, BUSY});
    @(negedge CLK);
    chk("idle", 32'h0, {31'h0, BUSY});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task s_walk; setup(5'h0F, 32'h0000_1021); shift(32'h1, 1); endtask
  // mask bit zero left clear must still feed back
  task s_crc16; setup(5'h0F, 32'h0000_1020); shift(32'h0000_3132, 16); endtask
  task s_crc32; setup(5'h1F, 32'h04C1_1DB6); shift(32'h3132_3334, 32); endtask
  // taps at and above the order are ignored, the top term still acts
  task s_short; setup(5'h04, 32'hFFFF_FFE0); shift(32'h0000_00A5, 8); endtask
  // clear offered with a data bit must win, while busy still shows the bit
  task s_clear;
    setup(5'h0F, 32'h0000_1021);
    shift(32'h0000_0001, 1);
    @(posedge CLK);
    DATA_VALID <= 1;
    DATA_BIT <= 1;
    CLEAR <= 1;
    @(posedge CLK);
    DATA_VALID <= 0;
    CLEAR <= 0;
    e_q = '0;
    @(negedge CLK);
    chk("clear wins", 32'h0000_0000, RESULT);
    chk("clear busy", 32'h1, {31'h0, BUSY});
  endtask
  task s_reset;
    setup(5'h07, 32'h0000_0007);
    shift(32'h0000_00FF, 8);
    @(posedge CLK);
    RSTN <= 0;
    @(negedge CLK);
    chk("rst result", 32'h0000_0000, RESULT);
    @(posedge CLK);
    RSTN <= 1;
    e_q = '0;
    shift(32'h0000_0001, 1);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLK);
    RSTN <= 1;
    s_walk;
    s_crc16;
    s_crc32;
    s_short;
    s_clear;
    s_reset;
    complete_run;
  end
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    n_fail++;
    complete_run;
  end
endmodule
